/* File: logic/eia_pkg.sv */
// eia_pkg: register indices, field layout, widths and reset values of the
// extended interrupt aggregator.
// assumes a 32-bit wishbone slave where byte address = 4 * register index.
package eia_pkg;

  // register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_EXT_CTL = 8'h61;
  localparam logic [7:0] IDX_EXT_FLG = 8'h62;
  localparam logic [7:0] IDX_EXT_MSK = 8'h63;
  localparam logic [7:0] IDX_EXT_ACK = 8'h65;
  localparam logic [7:0] IDX_ADD_CTL = 8'h66;
  localparam logic [7:0] IDX_ADD_FLG = 8'h67;
  localparam logic [7:0] IDX_ADD_MSK = 8'h6a;
  localparam logic [7:0] IDX_SUM_CTL = 8'h71;
  localparam logic [7:0] IDX_SUM_FLG = 8'h72;
  localparam logic [7:0] IDX_SUM_MSK = 8'h73;
  // system interrupt status (read only), clear (write only), enable
  localparam logic [7:0] IDX_SYS_STS = 8'h74;
  localparam logic [7:0] IDX_SYS_CLR = 8'h75;
  localparam logic [7:0] IDX_SYS_EN = 8'h76;

  // group widths
  localparam int EXT_W = 2;
  localparam int ADD_W = 8;
  localparam int SUM_W = 6;
  localparam int SYS_W = 3;
  localparam int J_W = 4;
  localparam int K_W = 4;

  // extended group bit positions
  localparam int EXT_GPIO = 0;
  localparam int EXT_ADDON = 1;

  // summary group bit positions, one per port family
  localparam int SUM_A = 0;
  localparam int SUM_E = 1;
  localparam int SUM_G = 2;
  localparam int SUM_J = 3;
  localparam int SUM_K = 4;
  localparam int SUM_L = 5;

  // system status bit positions: a group request rose
  localparam int SYS_EXT = 0;
  localparam int SYS_ADD = 1;
  localparam int SYS_SUM = 2;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage : eia_pkg

/* File: logic/eia_flag_bank.sv */
// eia_flag_bank: a row of sticky flags with per-bit set and clear.
// assumes set and clear come from logic on the same clock.
`timescale 1ns/1ns
module eia_flag_bank #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] flags_o
);
  import eia_pkg::*;

  typedef struct packed {
    logic [W-1:0] flags;
  } eia_bank_s;

  eia_bank_s st;
  eia_bank_s next_st;

  if (W < 1) begin : g_chk
    $error("eia_flag_bank: W must be at least 1");
  end

  // set wins over clear so an event in the clearing cycle is kept
  always_comb begin
    next_st = st;
    next_st.flags = (st.flags & ~clr_i) | set_i;
  end

  // every flag is zero after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flags_o = st.flags;

endmodule : eia_flag_bank

/* File: logic/eia_aggregator.sv */
// eia_aggregator: three interrupt aggregation groups (extended, add-on,
// pin-change summary) plus a system status/enable layer, on wishbone.
// assumes event sources and the core share clk_i; no synchronisers needed.
`timescale 1ns/1ns
module eia_aggregator #(
  parameter int AW = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // extended group: level requests, bit 0 gpio, bit 1 add-on block
  input wire logic [eia_pkg::EXT_W-1:0] ext_req_i,
  // core took the extended interrupt, one-cycle pulse per bit
  input wire logic [eia_pkg::EXT_W-1:0] ext_taken_i,
  // add-on group notifications, one-cycle pulses
  input wire logic [eia_pkg::ADD_W-1:0] addon_note_i,
  // pin-change notifications per port family, one-cycle pulses
  input wire logic pc_a_i,
  input wire logic pc_e_i,
  input wire logic pc_g_i,
  input wire logic [eia_pkg::J_W-1:0] pc_j_i,
  input wire logic [eia_pkg::K_W-1:0] pc_k_i,
  input wire logic pc_l_i,
  // requests to the core and the system interrupt
  output logic ext_irq_o,
  output logic addon_irq_o,
  output logic summary_irq_o,
  output logic irq_o
);
  import eia_pkg::*;

  if (AW < 10) begin : g_chk
    $error("eia_aggregator: AW must be at least 10");
  end

  // every group lives in one byte register, so no group may be wider
  if (EXT_W > 8 || SUM_W > 8 || SYS_W > 8) begin : g_chk_w
    $error("eia_aggregator: group widths must fit a byte");
  end

  // the add-on registers are read and written whole, without casts
  if (ADD_W != 8) begin : g_chk_add
    $error("eia_aggregator: ADD_W must be 8");
  end

  // a family with no ports would leave its summary bit undriven
  if (J_W < 1 || K_W < 1) begin : g_chk_jk
    $error("eia_aggregator: J_W and K_W must be at least 1");
  end

  // all registered state of the block apart from the flag banks
  typedef struct packed {
    logic [EXT_W-1:0] ext_irq_control;
    logic [EXT_W-1:0] ext_irq_mask;
    logic [ADD_W-1:0] addon_irq_control;
    logic [ADD_W-1:0] addon_irq_mask;
    logic [SUM_W-1:0] pinchange_summary_control;
    logic [SUM_W-1:0] pinchange_summary_mask;
    logic [SYS_W-1:0] sys_enable;
    logic [SYS_W-1:0] req;
    logic irq;
    logic ack;
    logic [31:0] dat;
  } eia_state_s;

  eia_state_s st;
  eia_state_s next_st;

  // flag bank outputs
  logic [EXT_W-1:0] ext_irq_flags;
  logic [EXT_W-1:0] ext_irq_acknowledge;
  logic [ADD_W-1:0] addon_irq_flags;
  logic [SUM_W-1:0] pinchange_summary_flags;
  logic [SYS_W-1:0] sys_status;

  // flag bank controls, driven by the continuous assignments below
  logic [EXT_W-1:0] ext_flg_set;
  logic [EXT_W-1:0] ext_flg_clr;
  logic [EXT_W-1:0] ext_ack_set;
  logic [EXT_W-1:0] ext_ack_clr;
  logic [ADD_W-1:0] add_flg_set;
  logic [ADD_W-1:0] add_flg_clr;
  logic [SUM_W-1:0] sum_flg_set;
  logic [SUM_W-1:0] sum_flg_clr;
  logic [SYS_W-1:0] sys_set;
  logic [SYS_W-1:0] sys_clr;

  // helpers
  logic [SUM_W-1:0] sum_note;
  logic [SYS_W-1:0] req_now;
  logic wr;
  logic [7:0] wd;
  logic [7:0] rd;

  // register index match; address bits 1:0 are ignored
  // every byte within a word decodes to the same register
  function automatic logic hit(input logic [AW-1:0] adr,
                               input logic [7:0] idx);
    hit = (adr[AW-1:2] == (AW-2)'(idx));
  endfunction : hit

  // write-one-to-clear mask of a byte written at one index
  function automatic logic [7:0] w1c(input logic w,
                                     input logic [AW-1:0] adr,
                                     input logic [7:0] idx,
                                     input logic [7:0] d);
    w1c = (w && hit(adr, idx)) ? d : RST_BYTE;
  endfunction : w1c

  // a write lands on the edge where the master samples ack high;
  // only byte lane 0 carries register data
  // a write with sel[0] low is still acknowledged but changes nothing
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & st.ack & wb_sel_i[0];
  assign wd = wb_dat_i[7:0];

  // pin-change families; j and k ports fold into single bits
  // folding before the mask means one mask bit covers all four ports
  assign sum_note[SUM_A] = pc_a_i;
  assign sum_note[SUM_E] = pc_e_i;
  assign sum_note[SUM_G] = pc_g_i;
  assign sum_note[SUM_J] = |pc_j_i;
  assign sum_note[SUM_K] = |pc_k_i;
  assign sum_note[SUM_L] = pc_l_i;

  // live group requests, registered below so outputs come from flops
  assign req_now[SYS_EXT] = |(ext_irq_flags & st.ext_irq_control);
  assign req_now[SYS_ADD] = |(addon_irq_flags & st.addon_irq_control);
  assign req_now[SYS_SUM] =
    |(pinchange_summary_flags & st.pinchange_summary_control);

  // extended group: set needs mask and no pending ack
  // a request held high cannot re-flag until software releases the ack
  assign ext_flg_set = ext_req_i & st.ext_irq_mask
                       & ~ext_irq_acknowledge;
  // cleared by ack, by a withdrawn request, or by a one written
  assign ext_flg_clr = ext_irq_acknowledge | ~ext_req_i
    | EXT_W'(w1c(wr, wb_adr_i, IDX_EXT_FLG, wd));
  // the core's response to a delivered interrupt
  assign ext_ack_set = ext_taken_i;
  // software releases the ack with a one write
  assign ext_ack_clr = EXT_W'(w1c(wr, wb_adr_i, IDX_EXT_ACK, wd));

  // add-on group: masked notification sets, one write clears
  assign add_flg_set = addon_note_i & st.addon_irq_mask;
  assign add_flg_clr = w1c(wr, wb_adr_i, IDX_ADD_FLG, wd);

  // summary group: masked family notification sets, one write clears
  assign sum_flg_set = sum_note & st.pinchange_summary_mask;
  assign sum_flg_clr = SUM_W'(w1c(wr, wb_adr_i, IDX_SUM_FLG, wd));

  // system status records each rising group request
  // only the rise is recorded, so a held request does not refill status
  assign sys_set = req_now & ~st.req;
  assign sys_clr = SYS_W'(w1c(wr, wb_adr_i, IDX_SYS_CLR, wd));

  // extended flags
  eia_flag_bank #(.W(EXT_W)) u_ext_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(ext_flg_set),
    .clr_i(ext_flg_clr),
    .flags_o(ext_irq_flags)
  );

  // extended acknowledge bits, set by the core and released by software
  eia_flag_bank #(.W(EXT_W)) u_ext_ack (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(ext_ack_set),
    .clr_i(ext_ack_clr),
    .flags_o(ext_irq_acknowledge)
  );

  // add-on flags
  eia_flag_bank #(.W(ADD_W)) u_add_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(add_flg_set),
    .clr_i(add_flg_clr),
    .flags_o(addon_irq_flags)
  );

  // pin-change summary flags
  eia_flag_bank #(.W(SUM_W)) u_sum_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(sum_flg_set),
    .clr_i(sum_flg_clr),
    .flags_o(pinchange_summary_flags)
  );

  // sticky system status behind the single interrupt output
  eia_flag_bank #(.W(SYS_W)) u_sys_status (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(sys_set),
    .clr_i(sys_clr),
    .flags_o(sys_status)
  );

  // read mux; unused bits and unmapped indices read zero
  always_comb begin
    rd = RST_BYTE;
    if (hit(wb_adr_i, IDX_EXT_CTL)) begin
      rd = 8'(st.ext_irq_control);
    end else if (hit(wb_adr_i, IDX_EXT_FLG)) begin
      rd = 8'(ext_irq_flags);
    end else if (hit(wb_adr_i, IDX_EXT_MSK)) begin
      rd = 8'(st.ext_irq_mask);
    end else if (hit(wb_adr_i, IDX_EXT_ACK)) begin
      rd = 8'(ext_irq_acknowledge);
    end else if (hit(wb_adr_i, IDX_ADD_CTL)) begin
      rd = st.addon_irq_control;
    end else if (hit(wb_adr_i, IDX_ADD_FLG)) begin
      rd = addon_irq_flags;
    end else if (hit(wb_adr_i, IDX_ADD_MSK)) begin
      rd = st.addon_irq_mask;
    end else if (hit(wb_adr_i, IDX_SUM_CTL)) begin
      rd = 8'(st.pinchange_summary_control);
    end else if (hit(wb_adr_i, IDX_SUM_FLG)) begin
      rd = 8'(pinchange_summary_flags);
    end else if (hit(wb_adr_i, IDX_SUM_MSK)) begin
      rd = 8'(st.pinchange_summary_mask);
    end else if (hit(wb_adr_i, IDX_SYS_STS)) begin
      rd = 8'(sys_status);
    end else if (hit(wb_adr_i, IDX_SYS_EN)) begin
      rd = 8'(st.sys_enable);
    end
  end

  // next state: bus handshake, plain read/write registers, requests
  always_comb begin
    next_st = st;
    // ack one cycle after the request, dropped in the following cycle
    next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
    // read data is captured with the ack so it is stable while ack is high
    if (wb_cyc_i && wb_stb_i && !st.ack) begin
      next_st.dat = {24'h00_0000, rd};
    end else begin
      next_st.dat = st.dat;
    end
    // plain registers take the written byte's low bits up to their width; summary mask and control have
    // no bit operations, software must read-modify-write them
    if (wr) begin
      if (hit(wb_adr_i, IDX_EXT_CTL)) begin
        next_st.ext_irq_control = wd[EXT_W-1:0];
      end else if (hit(wb_adr_i, IDX_EXT_MSK)) begin
        next_st.ext_irq_mask = wd[EXT_W-1:0];
      end else if (hit(wb_adr_i, IDX_ADD_CTL)) begin
        next_st.addon_irq_control = wd;
      end else if (hit(wb_adr_i, IDX_ADD_MSK)) begin
        next_st.addon_irq_mask = wd;
      end else if (hit(wb_adr_i, IDX_SUM_CTL)) begin
        next_st.pinchange_summary_control = wd[SUM_W-1:0];
      end else if (hit(wb_adr_i, IDX_SUM_MSK)) begin
        next_st.pinchange_summary_mask = wd[SUM_W-1:0];
      end else if (hit(wb_adr_i, IDX_SYS_EN)) begin
        next_st.sys_enable = wd[SYS_W-1:0];
      end
    end
    // group requests lag the flags by one cycle; the trade buys
    // flop-driven outputs at the cost of one cycle of latency
    next_st.req = req_now;
    // system interrupt: any enabled sticky status bit
    next_st.irq = |(sys_status & st.sys_enable);
  end

  // single state register; everything is zero after reset
  // a synchronous reset keeps the whole block in the clk_i domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
  assign ext_irq_o = st.req[SYS_EXT];
  assign addon_irq_o = st.req[SYS_ADD];
  assign summary_irq_o = st.req[SYS_SUM];
  assign irq_o = st.irq;

endmodule : eia_aggregator

/* File: sim/eia_aggregator_sva.sv */
// eia_aggregator_sva: timing checks on the aggregator's ports.
// assumes it is bound into eia_aggregator; one clock, sync reset.
`timescale 1ns/1ns
module eia_aggregator_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [eia_pkg::EXT_W-1:0] ext_req_i,
  input wire logic [eia_pkg::EXT_W-1:0] ext_taken_i,
  input wire logic ext_irq_o,
  input wire logic addon_irq_o,
  input wire logic summary_irq_o,
  input wire logic irq_o
);
  import eia_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // reset is watched itself, so it must not disable this one
  property p_rst_quiet; disable iff (1'b0) rst_i |=> !wb_ack_o &&
    !ext_irq_o && !addon_irq_o && !summary_irq_o && !irq_o; endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not quiet after reset");
  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("bus request not answered next cycle");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_ack_idle: assert property (p_ack_idle)
    else $error("ack without a request");
  property p_rd_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data upper bits not zero");
  // both ack bits set: the flags drop and the request follows
  property p_ack_blocks; ext_taken_i == 2'b11 |-> ##3 !ext_irq_o; endproperty
  a_ack_blocks: assert property (p_ack_blocks)
    else $error("extended request survives acknowledge");
  property p_withdraw; (ext_req_i == 2'b00) [*3] |-> !ext_irq_o; endproperty
  a_withdraw: assert property (p_withdraw)
    else $error("extended request survives source withdrawal");
  property p_ext_cause;
    $rose(ext_irq_o) |-> $past(ext_req_i, 2) != 2'b00; endproperty
  a_ext_cause: assert property (p_ext_cause)
    else $error("extended request rose with no source");
endmodule : eia_aggregator_sva

bind eia_aggregator eia_aggregator_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_req_i(ext_req_i),
  .ext_taken_i(ext_taken_i), .ext_irq_o(ext_irq_o),
  .addon_irq_o(addon_irq_o), .summary_irq_o(summary_irq_o), .irq_o(irq_o)
);

/* File: sim/eia_core_model.sv */
// eia_core_model: the core taking the extended request.
// assumes the aggregator's clock and sync reset.
`timescale 1ns/1ns
module eia_core_model #(
  parameter int DELAY = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic irq_i,
  input wire logic take_en_i,
  input wire logic [1:0] sel_i,
  output logic [1:0] taken_o
);
  logic [7:0] cnt;
  // one pulse per request; the count parks so a held request is not
  // answered twice, which would hide a missing flag clear
  always_ff @(posedge clk_i) begin
    if (rst_i || !irq_i || !take_en_i) begin
      cnt <= 8'h00;
      taken_o <= 2'b00;
    end else begin
      taken_o <= (cnt == DELAY) ? sel_i : 2'b00;
      if (cnt <= DELAY) cnt <= cnt + 8'h01;
    end
  end
endmodule : eia_core_model

/* File: sim/tb_eia_aggregator.sv */
// tb_eia_aggregator: register tests of the aggregator over wishbone.
// assumes byte address = 4 * index and a core model on the ext request.
`timescale 1ns/1ns
module tb_eia_aggregator;
  import eia_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, take = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0, pj = 4'h0, pk = 4'h0, ps = 4'h0;
  logic [31:0] wd = 32'h0000_0000, rd_o, q;
  logic [1:0] req = 2'b00, taken;
  logic [7:0] note = 8'h00;
  logic ack, eirq, airq, sirq, irq;
  int errors = 0, compares = 0;

  always #25 clk_i = ~clk_i;

  eia_aggregator #(.AW(10)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rd_o), .wb_ack_o(ack), .ext_req_i(req), .ext_taken_i(taken),
    .addon_note_i(note), .pc_a_i(ps[0]), .pc_e_i(ps[1]), .pc_g_i(ps[2]),
    .pc_j_i(pj), .pc_k_i(pk), .pc_l_i(ps[3]), .ext_irq_o(eirq),
    .addon_irq_o(airq), .summary_irq_o(sirq), .irq_o(irq));
  eia_core_model #(.DELAY(3)) core (.clk_i(clk_i), .rst_i(rst_i),
    .irq_i(eirq), .take_en_i(take), .sel_i(2'b11), .taken_o(taken));

  task automatic stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // classic cycle: hold until ack is sampled, then one idle cycle
  task automatic xfer(input logic w, input logic [7:0] i, d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {i, 2'b00};
    wd <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n == 20) errors++;
    q = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] i, d);
    xfer(1'b1, i, d);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] i, e);
    xfer(1'b0, i, 8'h00);
    chk(n, {24'h00_0000, e}, q);
  endtask : rd

  // one-cycle pin-change notification, then let it reach the flags
  task automatic pulse(input logic [3:0] s, j, k);
    @(posedge clk_i);
    ps <= s;
    pj <= j;
    pk <= k;
    @(posedge clk_i);
    ps <= 4'h0;
    pj <= 4'h0;
    pk <= 4'h0;
    repeat (3) @(posedge clk_i);
  endtask : pulse

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk_i);
    errors++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 8'h61; i <= 8'h76; i++) rd("reset", i[7:0], 8'h00);
    wr(8'h10, 8'hff);
    rd("unmapped", 8'h10, 8'h00);
    // add-on group: mask, control, clear by writing ones
    wr(IDX_ADD_MSK, 8'h0f);
    @(posedge clk_i);
    note <= 8'hff;
    @(posedge clk_i);
    note <= 8'h00;
    repeat (3) @(posedge clk_i);
    rd("add_flg", IDX_ADD_FLG, 8'h0f);
    chk("add_irq", 0, airq);
    wr(IDX_ADD_CTL, 8'h02);
    wr(IDX_SYS_EN, 8'h02);
    repeat (2) @(posedge clk_i);
    chk("add_irq", 1, airq);
    chk("irq", 1, irq);
    wr(IDX_ADD_FLG, 8'h05);
    rd("add_flg", IDX_ADD_FLG, 8'h0a);
    wr(IDX_ADD_FLG, 8'h0a);
    rd("add_flg", IDX_ADD_FLG, 8'h00);
    chk("add_irq", 0, airq);
    wr(IDX_SYS_CLR, 8'h02);
    rd("sys_sts", IDX_SYS_STS, 8'h00);
    chk("irq", 0, irq);
    // summary group: single mask bits by read-modify-write
    rd("sum_msk", IDX_SUM_MSK, 8'h00);
    wr(IDX_SUM_MSK, q[7:0] | 8'h18);
    wr(IDX_SUM_CTL, 8'h08);
    pulse(4'hf, 4'h4, 4'h8);
    rd("sum_flg", IDX_SUM_FLG, 8'h18);
    chk("sum_irq", 1, sirq);
    wr(IDX_SUM_FLG, 8'h08);
    rd("sum_flg", IDX_SUM_FLG, 8'h10);
    chk("sum_irq", 0, sirq);
    rd("sum_msk", IDX_SUM_MSK, 8'h18);
    wr(IDX_SUM_MSK, q[7:0] | 8'h27);
    pulse(4'hf, 4'h1, 4'h2);
    rd("sum_flg", IDX_SUM_FLG, 8'h3f);
    // extended group: masked source, acknowledge, withdrawal
    wr(IDX_EXT_MSK, 8'h01);
    wr(IDX_EXT_CTL, 8'h03);
    req <= 2'b10;
    repeat (3) @(posedge clk_i);
    rd("ext_flg", IDX_EXT_FLG, 8'h00);
    req <= 2'b01;
    repeat (3) @(posedge clk_i);
    rd("ext_flg", IDX_EXT_FLG, 8'h01);
    chk("ext_irq", 1, eirq);
    take <= 1'b1;
    repeat (10) @(posedge clk_i);
    take <= 1'b0;
    rd("ext_ack", IDX_EXT_ACK, 8'h03);
    rd("ext_flg", IDX_EXT_FLG, 8'h00);
    chk("ext_irq", 0, eirq);
    wr(IDX_EXT_ACK, 8'h00);
    rd("ext_ack", IDX_EXT_ACK, 8'h03);
    wr(IDX_EXT_ACK, 8'h01);
    rd("ext_ack", IDX_EXT_ACK, 8'h02);
    rd("ext_flg", IDX_EXT_FLG, 8'h01);
    req <= 2'b00;
    repeat (3) @(posedge clk_i);
    rd("ext_flg", IDX_EXT_FLG, 8'h00);
    // status kept the extended and summary rises; enable both, then clear
    rd("sys_sts", IDX_SYS_STS, 8'h05);
    wr(IDX_SYS_EN, 8'h05);
    repeat (2) @(posedge clk_i);
    chk("irq", 1, irq);
    wr(IDX_SYS_CLR, 8'h05);
    rd("sys_sts", IDX_SYS_STS, 8'h00);
    chk("irq", 0, irq);
    stop_test();
  end
endmodule : tb_eia_aggregator
